// file: error_history_pkg.sv
// package for the error history log: parameter addresses, field layout, limits and wipe states
// assumes a single 100 MHz clock domain; shared by the log and its verification
package error_history_pkg;

   // parameter addresses as seen by the fieldbus or commissioning master
   localparam logic [15:0] ADDR_POWER_ON_CYCLES = 16'h3b04;
   localparam logic [15:0] ADDR_HISTORY_WIPE = 16'h3b08;
   localparam logic [15:0] ADDR_POINTER_REWIND = 16'h3b0a;
   localparam logic [15:0] ADDR_CODE_FETCH = 16'h3c02;
   localparam logic [15:0] ADDR_SEVERITY = 16'h3c04;
   localparam logic [15:0] ADDR_DETECT_TIME = 16'h3c06;
   localparam logic [15:0] ADDR_QUALIFIER = 16'h3c08;
   localparam logic [15:0] ADDR_ENABLE_COUNT = 16'h3c0a;
   localparam logic [15:0] ADDR_ENABLE_ELAPSED = 16'h3c0c;
   localparam logic [15:0] ADDR_BUS_VOLTAGE = 16'h3c0e;
   localparam logic [15:0] ADDR_MOTOR_SPEED = 16'h3c10;
   localparam logic [15:0] ADDR_MOTOR_CURRENT = 16'h3c12;
   localparam logic [15:0] ADDR_STAGE_TEMP = 16'h3c14;
   localparam logic [15:0] ADDR_DEVICE_TEMP = 16'h3c16;

   // history depth and value limits
   localparam int HISTORY_DEPTH = 10;
   localparam logic [15:0] SEVERITY_MAX = 16'h0004;
   localparam logic [31:0] DETECT_TIME_MAX = 32'h1fffffff;
   localparam logic [15:0] COMMAND_VALUE = 16'h0001;
   localparam logic [15:0] EMPTY_CODE = 16'h0000;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   // wipe sequencer, one-hot
   typedef enum logic [1:0] {
      WIPE_IDLE = 2'b01,
      WIPE_RUN = 2'b10
   } wipe_state_e;

   // snapshot of the drive taken at the moment an error is detected
   typedef struct packed {
      logic [15:0] code;
      logic [15:0] severity;
      logic [31:0] detect_time;
      logic [15:0] qualifier;
      logic [31:0] power_on_cycles;
      logic [15:0] enable_count;
      logic [15:0] enable_elapsed;
      logic [15:0] bus_voltage;
      logic signed [31:0] motor_speed;
      logic [15:0] motor_current;
      logic signed [15:0] stage_temp;
      logic signed [15:0] device_temp;
   } err_entry_s;

   // one parameter access from the master
   typedef struct packed {
      logic we;
      logic [15:0] addr;
      logic [31:0] wdata;
   } par_req_s;

endpackage

// file: error_history_log.sv
// error history log: ten retained error snapshots, sequential read with holding buffer, wipe
// assumes parameter requests and error captures are synchronous one-cycle pulses on i_clk
`timescale 1ns/1ns

module error_history_log #(
   parameter int DEPTH = error_history_pkg::HISTORY_DEPTH
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_nv_valid,
   input wire logic i_err_valid,
   input wire error_history_pkg::err_entry_s i_err_entry,
   input wire logic i_par_req,
   input wire error_history_pkg::par_req_s i_par,
   output logic o_par_ack,
   output logic o_par_err,
   output logic [31:0] o_par_rdata,
   output logic o_wipe_busy,
   output logic [3:0] o_entry_count
);

   // pointer and count are four bits wide, so the depth must fit in them
   generate
      if (DEPTH < 1 || DEPTH > 15)
      begin : g_depth_check
         $error("error_history_log: DEPTH must lie in 1..15");
      end
   endgenerate

   localparam logic [3:0] DEPTH_L = 4'(DEPTH);
   localparam logic [3:0] LAST_L = 4'(DEPTH - 1);

   // true for every address the log answers; used by the read decode only
   function automatic logic addr_known(input logic [15:0] a);
      case (a)
         error_history_pkg::ADDR_POWER_ON_CYCLES,
         error_history_pkg::ADDR_HISTORY_WIPE,
         error_history_pkg::ADDR_POINTER_REWIND,
         error_history_pkg::ADDR_CODE_FETCH,
         error_history_pkg::ADDR_SEVERITY,
         error_history_pkg::ADDR_DETECT_TIME,
         error_history_pkg::ADDR_QUALIFIER,
         error_history_pkg::ADDR_ENABLE_COUNT,
         error_history_pkg::ADDR_ENABLE_ELAPSED,
         error_history_pkg::ADDR_BUS_VOLTAGE,
         error_history_pkg::ADDR_MOTOR_SPEED,
         error_history_pkg::ADDR_MOTOR_CURRENT,
         error_history_pkg::ADDR_STAGE_TEMP,
         error_history_pkg::ADDR_DEVICE_TEMP: addr_known = 1'b1;
         default: addr_known = 1'b0;
      endcase
   endfunction

   // true for addresses that accept a write
   function automatic logic addr_writable(input logic [15:0] a);
      addr_writable = (a == error_history_pkg::ADDR_HISTORY_WIPE) ||
                      (a == error_history_pkg::ADDR_POINTER_REWIND);
   endfunction

   // retained entry store: no reset so contents outlive a power cycle
   error_history_pkg::err_entry_s store_r [DEPTH];
   logic [3:0] count_r;
   logic [3:0] count_nxt;

   logic [3:0] rd_ptr_r;
   error_history_pkg::err_entry_s hold_r;
   error_history_pkg::wipe_state_e wipe_state_r;
   logic [3:0] wipe_idx_r;
   logic nv_checked_r;

   // decoded request strobes
   logic rd_req;
   logic wr_req;
   logic rewind_cmd;
   logic wipe_cmd;
   logic fetch_req;
   logic fetch_hit;
   logic wiping;
   logic capture;
   logic capture_full;
   error_history_pkg::err_entry_s snap;
   // wipe start and the busy mirror's next value
   logic wipe_start;
   logic wipe_run_nxt;

   assign rd_req = i_par_req && !i_par.we && addr_known(i_par.addr);
   assign wr_req = i_par_req && i_par.we && addr_writable(i_par.addr);
   assign rewind_cmd = wr_req && (i_par.addr == error_history_pkg::ADDR_POINTER_REWIND) &&
                       (i_par.wdata[15:0] == error_history_pkg::COMMAND_VALUE);
   assign wipe_cmd = wr_req && (i_par.addr == error_history_pkg::ADDR_HISTORY_WIPE) &&
                     (i_par.wdata[15:0] == error_history_pkg::COMMAND_VALUE);
   assign fetch_req = rd_req && (i_par.addr == error_history_pkg::ADDR_CODE_FETCH);
   assign wiping = (wipe_state_r == error_history_pkg::WIPE_RUN);
   // a fetch finds an entry only inside the filled part and never during a wipe
   assign fetch_hit = fetch_req && !wiping && (rd_ptr_r < count_r);
   // captures during a wipe are dropped so the wipe leaves an empty history
   assign capture = i_err_valid && !wiping;
   assign capture_full = capture && (count_r == DEPTH_L);

   // a stale or corrupt retained image at boot is treated like a wipe request
   assign wipe_start = !wiping && (wipe_cmd || (!nv_checked_r && !i_nv_valid));
   // busy follows the sequencer's next state, so it stands exactly while a wipe read returns nonzero
   assign wipe_run_nxt = wiping ? (wipe_idx_r != LAST_L) : wipe_start;

   // clamp the snapshot to the ranges the fields may report
   always_comb
   begin
      snap = i_err_entry;
      if (i_err_entry.severity > error_history_pkg::SEVERITY_MAX)
      begin
         snap.severity = error_history_pkg::SEVERITY_MAX;
      end
      if (i_err_entry.detect_time > error_history_pkg::DETECT_TIME_MAX)
      begin
         snap.detect_time = error_history_pkg::DETECT_TIME_MAX;
      end
   end

   // entry store: append while room remains, otherwise shift toward position 0
   generate
      for (genvar g = 0; g < DEPTH; g++)
      begin : g_entry
         // the last slot names itself so the shift source never leaves the array
         localparam int NEXT = (g + 1 < DEPTH) ? g + 1 : g;
         always_ff @(posedge i_clk)
         begin
            if (capture_full)
            begin
               if (g == DEPTH - 1)
               begin
                  store_r[g] <= snap;
               end
               else
               begin
                  store_r[g] <= store_r[NEXT];
               end
            end
            else if (capture && (count_r == 4'(g)))
            begin
               store_r[g] <= snap;
            end
            else if (wiping && (wipe_idx_r == 4'(g)))
            begin
               store_r[g] <= '0;
            end
         end
      end
   endgenerate

   // entry count: retained like the store; a wipe or a lost image empties it
   always_comb
   begin
      count_nxt = count_r;
      if (wiping)
      begin
         count_nxt = 4'h0;
      end
      else if (capture && (count_r < DEPTH_L))
      begin
         count_nxt = count_r + 4'h1;
      end
   end

   // no reset: the count is retained together with the store
   always_ff @(posedge i_clk)
   begin
      count_r <= count_nxt;
   end

   // retained image check, taken once after reset release
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         nv_checked_r <= 1'b0;
      end
      else
      begin
         nv_checked_r <= 1'b1;
      end
   end

   // wipe sequencer: clears one slot a cycle so the master sees a busy phase
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         wipe_state_r <= error_history_pkg::WIPE_IDLE;
         wipe_idx_r <= 4'h0;
      end
      else
      begin
         case (wipe_state_r)
            error_history_pkg::WIPE_IDLE:
            begin
               wipe_idx_r <= 4'h0;
               if (wipe_start)
               begin
                  wipe_state_r <= error_history_pkg::WIPE_RUN;
               end
            end
            error_history_pkg::WIPE_RUN:
            begin
               if (wipe_idx_r == LAST_L)
               begin
                  wipe_state_r <= error_history_pkg::WIPE_IDLE;
                  wipe_idx_r <= 4'h0;
               end
               else
               begin
                  wipe_idx_r <= wipe_idx_r + 4'h1;
               end
            end
            default:
            begin
               wipe_state_r <= error_history_pkg::WIPE_IDLE;
               wipe_idx_r <= 4'h0;
            end
         endcase
      end
   end

   // read pointer: rewind wins over a fetch in the same cycle, wipe rewinds too
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rd_ptr_r <= 4'h0;
      end
      else if (rewind_cmd || wiping)
      begin
         rd_ptr_r <= 4'h0;
      end
      else if (fetch_hit)
      begin
         rd_ptr_r <= rd_ptr_r + 4'h1;
      end
   end

   // holding buffer: a fetch copies the whole entry, or clears it past the end
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         hold_r <= '0;
      end
      else if (fetch_hit)
      begin
         hold_r <= store_r[rd_ptr_r];
      end
      else if (fetch_req)
      begin
         hold_r <= '0;
      end
   end

   // read mux; fields come from the holding buffer, only the code fetch reads straight from the store
   logic [31:0] rdata_nxt;

   always_comb
   begin
      rdata_nxt = error_history_pkg::READ_ZERO;
      case (i_par.addr)
         error_history_pkg::ADDR_CODE_FETCH:
         begin
            if (fetch_hit)
            begin
               rdata_nxt = {16'h0000, store_r[rd_ptr_r].code};
            end
            else
            begin
               rdata_nxt = {16'h0000, error_history_pkg::EMPTY_CODE};
            end
         end
         error_history_pkg::ADDR_HISTORY_WIPE:
         begin
            rdata_nxt = {31'h0000_0000, wiping || wipe_cmd};
         end
         error_history_pkg::ADDR_POINTER_REWIND: rdata_nxt = error_history_pkg::READ_ZERO;
         error_history_pkg::ADDR_POWER_ON_CYCLES: rdata_nxt = hold_r.power_on_cycles;
         error_history_pkg::ADDR_SEVERITY: rdata_nxt = {16'h0000, hold_r.severity};
         error_history_pkg::ADDR_DETECT_TIME: rdata_nxt = hold_r.detect_time;
         error_history_pkg::ADDR_QUALIFIER: rdata_nxt = {16'h0000, hold_r.qualifier};
         error_history_pkg::ADDR_ENABLE_COUNT: rdata_nxt = {16'h0000, hold_r.enable_count};
         error_history_pkg::ADDR_ENABLE_ELAPSED: rdata_nxt = {16'h0000, hold_r.enable_elapsed};
         error_history_pkg::ADDR_BUS_VOLTAGE: rdata_nxt = {16'h0000, hold_r.bus_voltage};
         error_history_pkg::ADDR_MOTOR_SPEED: rdata_nxt = hold_r.motor_speed;
         error_history_pkg::ADDR_MOTOR_CURRENT: rdata_nxt = {16'h0000, hold_r.motor_current};
         // temperatures are sign extended so a 32-bit reader keeps their sign
         error_history_pkg::ADDR_STAGE_TEMP: rdata_nxt = 32'(hold_r.stage_temp);
         error_history_pkg::ADDR_DEVICE_TEMP: rdata_nxt = 32'(hold_r.device_temp);
         default: rdata_nxt = error_history_pkg::READ_ZERO;
      endcase
   end

   // answer one cycle after every request; unmapped or read-only writes flag an error
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_par_ack <= 1'b0;
         o_par_err <= 1'b0;
      end
      else
      begin
         o_par_ack <= i_par_req;
         o_par_err <= i_par_req && !(rd_req || wr_req);
      end
   end

   // read data stands for the ack cycle only and is zero otherwise, so stale fields never leak
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_par_rdata <= error_history_pkg::READ_ZERO;
      end
      else
      begin
         o_par_rdata <= rd_req ? rdata_nxt : error_history_pkg::READ_ZERO;
      end
   end

   // busy mirror for the surrounding drive logic
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_wipe_busy <= 1'b0;
      end
      else
      begin
         o_wipe_busy <= wipe_run_nxt;
      end
   end

   // entry count mirror; zero in reset although the store itself is retained
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_entry_count <= 4'h0;
      end
      else
      begin
         o_entry_count <= count_nxt;
      end
   end

endmodule // error_history_log

// file: error_history_log_properties.sv
// concurrent checks on the error history log parameter port, capture port and wipe sequencer
// assumes DEPTH 10, so a wipe holds busy for ten cycles
`timescale 1ns/1ns

module error_history_log_properties (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_err_valid,
   input wire logic i_par_req,
   input wire error_history_pkg::par_req_s i_par,
   input wire logic o_par_ack,
   input wire logic o_par_err,
   input wire logic [31:0] o_par_rdata,
   input wire logic o_wipe_busy,
   input wire logic [3:0] o_entry_count
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);

   // decoded requests, kept as nets so the properties stay short
   wire logic wipe_cmd = i_par_req && i_par.we && i_par.addr == error_history_pkg::ADDR_HISTORY_WIPE
                         && i_par.wdata[15:0] == 16'h0001;
   wire logic wipe_rd = i_par_req && !i_par.we && i_par.addr == error_history_pkg::ADDR_HISTORY_WIPE;
   wire logic ro_wr = i_par_req && i_par.we && i_par.addr == error_history_pkg::ADDR_SEVERITY;

   // ten busy cycles, then idle
   sequence s_wipe_run;
      o_wipe_busy [*8] ##1 o_wipe_busy ##1 o_wipe_busy ##1 !o_wipe_busy;
   endsequence
   sequence s_wipe_begin;
      o_wipe_busy ##1 (o_entry_count == 4'h0);
   endsequence

   property p_ack;
      i_par_req |=> o_par_ack;
   endproperty
   property p_quiet;
      !i_par_req |=> !o_par_ack && !o_par_err && o_par_rdata == 32'h0;
   endproperty
   property p_err_ro;
      ro_wr |=> o_par_ack && o_par_err;
   endproperty
   property p_wipe_start;
      wipe_cmd && !o_wipe_busy |=> s_wipe_begin;
   endproperty
   property p_wipe_len;
      $rose(o_wipe_busy) |-> s_wipe_run;
   endproperty
   property p_wipe_read;
      wipe_rd && o_wipe_busy |=> o_par_rdata == 32'h1;
   endproperty
   property p_count_inc;
      i_err_valid && !o_wipe_busy && !wipe_cmd && o_entry_count < 4'ha |=>
         o_entry_count == $past(o_entry_count) + 4'h1;
   endproperty
   property p_count_sat;
      i_err_valid && !o_wipe_busy && o_entry_count == 4'ha |=> o_entry_count == 4'ha;
   endproperty

   a_ack: assert property (p_ack) else $error("no acknowledge one cycle after request");
   a_quiet: assert property (p_quiet) else $error("answer without request");
   a_err_ro: assert property (p_err_ro) else $error("read-only write not refused");
   a_wipe_start: assert property (p_wipe_start) else $error("wipe did not start at once");
   a_wipe_len: assert property (p_wipe_len) else $error("wipe busy length wrong");
   a_wipe_read: assert property (p_wipe_read) else $error("wipe read not nonzero while busy");
   a_count_inc: assert property (p_count_inc) else $error("entry count not advanced");
   a_count_sat: assert property (p_count_sat) else $error("entry count left ten when full");
endmodule // error_history_log_properties

bind error_history_log error_history_log_properties u_props (
   .i_clk(i_clk),
   .i_rst_b(i_rst_b),
   .i_err_valid(i_err_valid),
   .i_par_req(i_par_req),
   .i_par(i_par),
   .o_par_ack(o_par_ack),
   .o_par_err(o_par_err),
   .o_par_rdata(o_par_rdata),
   .o_wipe_busy(o_wipe_busy),
   .o_entry_count(o_entry_count)
);

// file: history_master.sv
// parameter master model: one access at a time on the log's parameter port
// assumes one-cycle request pulses answered by an acknowledge one edge later
`timescale 1ns/1ns

module history_master (
   input wire logic i_clk,
   input wire logic i_par_ack,
   input wire logic i_par_err,
   input wire logic [31:0] i_par_rdata,
   output logic o_par_req,
   output error_history_pkg::par_req_s o_par
);
   initial
   begin
      o_par_req = 1'b0;
      o_par = '0;
   end

   // fields stay put until the answer is taken, then are scrambled so stale values never look valid
   task automatic access(input logic we, input logic [15:0] addr, input logic [31:0] wdata,
                         output logic [31:0] rdata, output logic err, output logic ok);
      int n;
      ok = 1'b0;
      rdata = 32'h0;
      err = 1'b0;
      @(posedge i_clk);
      #1;
      o_par_req = 1'b1;
      o_par = {we, addr, wdata};
      @(posedge i_clk);
      #1;
      o_par_req = 1'b0;
      for (n = 0; n < 4 && !ok; n++)
      begin
         if (i_par_ack === 1'b1)
         begin
            ok = 1'b1;
            rdata = i_par_rdata;
            err = i_par_err;
            o_par = ~o_par;
         end
         else
         begin
            @(posedge i_clk);
            #1;
         end
      end
   endtask
endmodule // history_master

// file: error_history_log_test.sv
// self-checking bench for the error history log, with a queue model of the stored entries
// assumes the log and the master model share one 100 MHz clock
`timescale 1ns/1ns

module error_history_log_test;
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_nv_valid = 1'b0;
   logic i_err_valid = 1'b0;
   error_history_pkg::err_entry_s i_err_entry = '0;
   logic par_req;
   error_history_pkg::par_req_s par;
   logic ack, perr, wipe_busy;
   logic [31:0] rdata;
   logic [3:0] entry_count;
   integer seed = 32'h48e9;
   int n_errors = 0;
   int tests_run = 0;
   int ptr = 0;
   int k, j;
   error_history_pkg::err_entry_s q[$];
   error_history_pkg::err_entry_s hb = '0;
   logic [15:0] fa [11] = '{error_history_pkg::ADDR_SEVERITY, error_history_pkg::ADDR_DETECT_TIME,
      error_history_pkg::ADDR_QUALIFIER, error_history_pkg::ADDR_ENABLE_COUNT, error_history_pkg::ADDR_ENABLE_ELAPSED,
      error_history_pkg::ADDR_BUS_VOLTAGE, error_history_pkg::ADDR_MOTOR_SPEED, error_history_pkg::ADDR_MOTOR_CURRENT,
      error_history_pkg::ADDR_STAGE_TEMP, error_history_pkg::ADDR_DEVICE_TEMP, error_history_pkg::ADDR_POWER_ON_CYCLES};

   always #5 i_clk = ~i_clk;

   error_history_log #(.DEPTH(10)) uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_nv_valid(i_nv_valid),
      .i_err_valid(i_err_valid), .i_err_entry(i_err_entry), .i_par_req(par_req), .i_par(par), .o_par_ack(ack),
      .o_par_err(perr), .o_par_rdata(rdata), .o_wipe_busy(wipe_busy), .o_entry_count(entry_count));
   history_master mst (.i_clk(i_clk), .i_par_ack(ack), .i_par_err(perr), .i_par_rdata(rdata),
      .o_par_req(par_req), .o_par(par));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("errors %0d of %0d compares", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // expected field value from a snapshot; temperatures widen with their sign
   function automatic logic [31:0] fexp(error_history_pkg::err_entry_s x, logic [15:0] a);
      case (a)
         error_history_pkg::ADDR_SEVERITY: return {16'h0, x.severity};
         error_history_pkg::ADDR_DETECT_TIME: return x.detect_time;
         error_history_pkg::ADDR_QUALIFIER: return {16'h0, x.qualifier};
         error_history_pkg::ADDR_ENABLE_COUNT: return {16'h0, x.enable_count};
         error_history_pkg::ADDR_ENABLE_ELAPSED: return {16'h0, x.enable_elapsed};
         error_history_pkg::ADDR_BUS_VOLTAGE: return {16'h0, x.bus_voltage};
         error_history_pkg::ADDR_MOTOR_SPEED: return x.motor_speed;
         error_history_pkg::ADDR_MOTOR_CURRENT: return {16'h0, x.motor_current};
         error_history_pkg::ADDR_STAGE_TEMP: return {{16{x.stage_temp[15]}}, x.stage_temp};
         error_history_pkg::ADDR_DEVICE_TEMP: return {{16{x.device_temp[15]}}, x.device_temp};
         default: return x.power_on_cycles;
      endcase
   endfunction

   task automatic acc(input logic we, input logic [15:0] a, input logic [31:0] d, input logic xe,
                      input logic [31:0] x);
      logic [31:0] r;
      logic e, ok;
      mst.access(we, a, d, r, e, ok);
      check({31'h0, ok}, 32'h1);
      if (!ok)
         print_verdict();
      check({31'h0, e}, {31'h0, xe});
      if (!we && !xe)
         check(r, x);
   endtask

   // model of a code fetch: load the holding buffer, step the pointer
   task automatic fetch();
      hb = (ptr < q.size()) ? q[ptr] : '0;
      if (ptr < q.size())
         ptr++;
      acc(1'b0, error_history_pkg::ADDR_CODE_FETCH, 32'h0, 1'b0, {16'h0, hb.code});
   endtask

   task automatic poll_wipe();
      logic [31:0] r;
      logic e, ok;
      for (j = 0; j < 40; j++)
      begin
         mst.access(1'b0, error_history_pkg::ADDR_HISTORY_WIPE, 32'h0, r, e, ok);
         if (ok && r === 32'h0)
            break;
      end
      check({31'h0, j < 40}, 32'h1);
      if (j >= 40)
         print_verdict();
      q = {};
      ptr = 0;
   endtask

   // back-to-back captures; severity and detect time clamp in the log
   task automatic cap(input int n);
      error_history_pkg::err_entry_s e;
      for (k = 0; k < n; k++)
      begin
         @(posedge i_clk);
         #1;
         e = 240'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed), $random(seed),
              $random(seed), $random(seed)});
         e.code[0] = 1'b1;
         e.severity = 16'($random(seed) & 7);
         i_err_valid = 1'b1;
         i_err_entry = e;
         if (e.severity > 16'h4)
            e.severity = 16'h4;
         if (e.detect_time > error_history_pkg::DETECT_TIME_MAX)
            e.detect_time = error_history_pkg::DETECT_TIME_MAX;
         q.push_back(e);
         if (q.size() > 10)
            void'(q.pop_front());
      end
      @(posedge i_clk);
      #1;
      i_err_valid = 1'b0;
   endtask

   initial
   begin
      repeat (5) @(posedge i_clk);
      #1;
      i_rst_b = 1'b1;
      poll_wipe();
      check({28'h0, entry_count}, 32'h0);
      acc(1'b1, error_history_pkg::ADDR_POINTER_REWIND, 32'h1, 1'b0, 32'h0);
      fetch();
      cap(12);
      check({28'h0, entry_count}, 32'ha);
      acc(1'b1, error_history_pkg::ADDR_POINTER_REWIND, 32'h1, 1'b0, 32'h0);
      ptr = 0;
      for (int m = 0; m < 11; m++)
      begin
         fetch();
         foreach (fa[i])
            acc(1'b0, fa[i], 32'h0, 1'b0, fexp(hb, fa[i]));
      end
      acc(1'b0, 16'h3b00, 32'h0, 1'b1, 32'h0);
      acc(1'b1, error_history_pkg::ADDR_SEVERITY, 32'h1, 1'b1, 32'h0);
      // second reset with a trusted image: entries must survive
      @(posedge i_clk);
      #1;
      i_nv_valid = 1'b1;
      i_rst_b = 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
      i_rst_b = 1'b1;
      ptr = 0;
      // the count mirror reloads from the retained count on the first edge after release
      @(posedge i_clk);
      #1;
      check({28'h0, entry_count}, 32'ha);
      acc(1'b1, error_history_pkg::ADDR_POINTER_REWIND, 32'h1, 1'b0, 32'h0);
      fetch();
      acc(1'b1, error_history_pkg::ADDR_HISTORY_WIPE, 32'h1, 1'b0, 32'h0);
      acc(1'b0, error_history_pkg::ADDR_CODE_FETCH, 32'h0, 1'b0, 32'h0);
      poll_wipe();
      check({28'h0, entry_count}, 32'h0);
      acc(1'b1, error_history_pkg::ADDR_POINTER_REWIND, 32'h1, 1'b0, 32'h0);
      fetch();
      print_verdict();
   end
endmodule // error_history_log_test
